// ### hdl/gpio_port_regs.sv
/*
  Register set for four port groups: a bidirectional group with pull-ups, an input-only group,
  an output-only group and a bidirectional group without pull-ups. Software reaches the
  registers over AHB-Lite; pad controls are registered outputs.
  Assumes pads resolve dout/oe/pu into the wire and return the wire level as pin inputs, and
  that alternate modules supply their own drive and output enable.
*/
// The AHB-Lite slave port and the address map were decided locally.
// Overview of operation
// R1: Alternate bit clear selects general-purpose pin use.
// R2: Alternate bit set hands pin to module.
// R3: Alternate selects reset to zero, per-pin exceptions.
// R4: Direction zero is input, one is output.
// R5: Direction registers reset to zero, exceptions allowed.
// R6: Output-data write drives pins, reads return register.
// R7: Input-data reads return live pin levels, read-only.
// R8: Pull-up only when enabled and undriven.
// R9: Pull-up applies in both pin uses.
// R10: Pull-up enables reset to zero.
// R11: Registers are eight bits, one pin per bit.
// R12: Each group has only its listed registers.
// R13: Output data drives only general-purpose outputs.
// R14: Open-drain: clear data, toggle direction (software).
// R15: Writes reach pins next cycle; inputs synchronised.
`timescale 1ns/100ps
module gpio_port_regs #(
  parameter gpio_port_pkg::port_t BIDIR_ALT_RST = gpio_port_pkg::RST_ALT,
  parameter gpio_port_pkg::port_t INPUT_ALT_RST = gpio_port_pkg::RST_ALT,
  parameter gpio_port_pkg::port_t OUTPUT_ALT_RST = gpio_port_pkg::RST_ALT,
  parameter gpio_port_pkg::port_t BIDIR_DIR_RST = gpio_port_pkg::RST_DIR,
  parameter gpio_port_pkg::port_t EMUL_DIR_RST  = gpio_port_pkg::RST_DIR
) (
  // Clock and reset.
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // AHB-Lite slave.
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output      logic [31:0]                hrdata,
  output      logic                       hreadyout,
  output      logic                       hresp,
  // Pin levels returned by the pads.
  input  wire gpio_port_pkg::port_t       bidir_pin_in,
  input  wire gpio_port_pkg::port_t       input_pin_in,
  input  wire gpio_port_pkg::port_t       emul_pin_in,
  // Alternate module drive.
  input  wire gpio_port_pkg::alt_drive_s  bidir_alt_drv,
  input  wire gpio_port_pkg::alt_drive_s  output_alt_drv,
  // Pad controls.
  output      gpio_port_pkg::pad_ctrl_s   bidir_pad,
  output      gpio_port_pkg::pad_ctrl_s   input_pad,
  output      gpio_port_pkg::pad_ctrl_s   output_pad,
  output      gpio_port_pkg::pad_ctrl_s   emul_pad,
  // Alternate select, seen by the alternate modules.
  output      gpio_port_pkg::port_t       bidir_alt_sel,
  output      gpio_port_pkg::port_t       input_alt_sel,
  output      gpio_port_pkg::port_t       output_alt_sel
);
  import gpio_port_pkg::*;

  // Software-visible registers, eight bits each. [R11]
  port_t bidir_alt_ff;
  port_t input_alt_ff;
  port_t output_alt_ff;
  port_t bidir_dir_ff;
  port_t emul_dir_ff;
  port_t bidir_out_ff;
  port_t output_out_ff;
  port_t emul_out_ff;
  port_t bidir_pu_ff;
  port_t input_pu_ff;

  // Data-phase state of the bus.
  logic              wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [31:0]       hrdata_ff;
  logic              hreadyout_ff;
  logic              hresp_ff;
  pad_ctrl_s         bidir_pad_ff;
  pad_ctrl_s         input_pad_ff;
  pad_ctrl_s         output_pad_ff;
  pad_ctrl_s         emul_pad_ff;

  port_t bidir_in_sync;
  port_t input_in_sync;
  port_t emul_in_sync;

  // Inputs pass two flip-flops before software sees them. [R15]
  gpio_sync u_sync_bidir (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_raw  (bidir_pin_in),
    .pin_sync (bidir_in_sync)
  );
  gpio_sync u_sync_input (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_raw  (input_pin_in),
    .pin_sync (input_in_sync)
  );
  gpio_sync u_sync_emul (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_raw  (emul_pin_in),
    .pin_sync (emul_in_sync)
  );

  // Address-phase decode.
  wire               xfer_ok  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire               wr_take  = xfer_ok && hwrite;
  wire               rd_take  = xfer_ok && !hwrite;
  wire [ADDR_W-1:0]  rd_addr  = haddr[ADDR_W-1:0];

  // Write decode in the data phase.
  wire   we_bidir_alt  = wr_pend_ff && (wr_addr_ff == OFS_BIDIR_ALT);
  wire   we_input_alt  = wr_pend_ff && (wr_addr_ff == OFS_INPUT_ALT);
  wire   we_output_alt = wr_pend_ff && (wr_addr_ff == OFS_OUTPUT_ALT);
  wire   we_bidir_dir  = wr_pend_ff && (wr_addr_ff == OFS_BIDIR_DIR);
  wire   we_emul_dir   = wr_pend_ff && (wr_addr_ff == OFS_EMUL_DIR);
  wire   we_bidir_out  = wr_pend_ff && (wr_addr_ff == OFS_BIDIR_OUT);
  wire   we_output_out = wr_pend_ff && (wr_addr_ff == OFS_OUTPUT_OUT);
  wire   we_emul_out   = wr_pend_ff && (wr_addr_ff == OFS_EMUL_OUT);
  wire   we_bidir_pu   = wr_pend_ff && (wr_addr_ff == OFS_BIDIR_PU);
  wire   we_input_pu   = wr_pend_ff && (wr_addr_ff == OFS_INPUT_PU);
  wire port_t wdat     = hwdata[PORT_W-1:0];

  // Read mux; the input-data registers have no write decode. [R7] [R12]
  port_t rd_sel;
  always_comb begin
    unique case (rd_addr)
      OFS_BIDIR_ALT:  rd_sel = bidir_alt_ff;
      OFS_INPUT_ALT:  rd_sel = input_alt_ff;
      OFS_OUTPUT_ALT: rd_sel = output_alt_ff;
      OFS_BIDIR_DIR:  rd_sel = bidir_dir_ff;
      OFS_EMUL_DIR:   rd_sel = emul_dir_ff;
      OFS_BIDIR_OUT:  rd_sel = bidir_out_ff;
      OFS_OUTPUT_OUT: rd_sel = output_out_ff;
      OFS_EMUL_OUT:   rd_sel = emul_out_ff;
      OFS_BIDIR_IN:   rd_sel = bidir_in_sync;
      OFS_INPUT_IN:   rd_sel = input_in_sync;
      OFS_EMUL_IN:    rd_sel = emul_in_sync;
      OFS_BIDIR_PU:   rd_sel = bidir_pu_ff;
      OFS_INPUT_PU:   rd_sel = input_pu_ff;
      default:        rd_sel = RST_OUT_DATA;
    endcase
  end
  wire [31:0] nxt_hrdata = rd_take ? {24'h000000, rd_sel} : hrdata_ff;

  // Pad equations for the bidirectional pull-up group.
  wire port_t bidir_gp_oe  = ~bidir_alt_ff & bidir_dir_ff; // [R1] [R4] [R13]
  wire port_t nxt_bidir_oe = bidir_gp_oe | (bidir_alt_ff & bidir_alt_drv.oe); // [R2]
  wire port_t nxt_bidir_do = (~bidir_alt_ff & bidir_out_ff) | (bidir_alt_ff & bidir_alt_drv.dout); // [R13]
  // Pull-up follows the undriven condition in either use. [R8] [R9]
  wire port_t nxt_bidir_pu = bidir_pu_ff & ~nxt_bidir_oe;

  // Output-only group: pad driven in general-purpose use, else by the alternate module's enable; source picked by alternate select.
  wire port_t nxt_output_do = (~output_alt_ff & output_out_ff) | (output_alt_ff & output_alt_drv.dout); // [R1] [R2]
  wire port_t nxt_output_oe = ~output_alt_ff | output_alt_drv.oe; // [R2]

  // Emulatable group: no alternate select, direction alone decides. [R4] [R12]
  wire port_t nxt_emul_oe = emul_dir_ff;
  wire port_t nxt_emul_do = emul_out_ff;

  // Input-only group never drives, so its pull-up follows the enable bit. [R8]
  wire pad_ctrl_s nxt_bidir_pad  = '{dout: nxt_bidir_do, oe: nxt_bidir_oe, pu: nxt_bidir_pu};
  wire pad_ctrl_s nxt_input_pad  = '{dout: RST_OUT_DATA, oe: RST_OUT_DATA, pu: input_pu_ff};
  wire pad_ctrl_s nxt_output_pad = '{dout: nxt_output_do, oe: nxt_output_oe, pu: RST_PULLUP};
  wire pad_ctrl_s nxt_emul_pad   = '{dout: nxt_emul_do, oe: nxt_emul_oe, pu: RST_PULLUP};

  // Bus state; every transfer completes with no wait state and OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_ff <= '0;
    end else begin
      wr_addr_ff <= rd_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Ready and response never change, yet leave the block from flip-flops like every other output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
    end
  end

  // Alternate select of the bidirectional group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_alt_ff <= BIDIR_ALT_RST; // [R3]
    end else if (we_bidir_alt) begin
      bidir_alt_ff <= wdat;
    end
  end

  // Alternate select of the input-only group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_alt_ff <= INPUT_ALT_RST; // [R3]
    end else if (we_input_alt) begin
      input_alt_ff <= wdat;
    end
  end

  // Alternate select of the output-only group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_alt_ff <= OUTPUT_ALT_RST; // [R3]
    end else if (we_output_alt) begin
      output_alt_ff <= wdat;
    end
  end

  // Direction of the bidirectional group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_dir_ff <= BIDIR_DIR_RST; // [R5]
    end else if (we_bidir_dir) begin
      bidir_dir_ff <= wdat;
    end
  end

  // Direction of the emulatable group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emul_dir_ff <= EMUL_DIR_RST; // [R5]
    end else if (we_emul_dir) begin
      emul_dir_ff <= wdat;
    end
  end

  // Output data holds the written value and reads back as written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_out_ff <= RST_OUT_DATA;
    end else if (we_bidir_out) begin
      bidir_out_ff <= wdat; // [R6]
    end
  end

  // Output data of the output-only group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_out_ff <= RST_OUT_DATA;
    end else if (we_output_out) begin
      output_out_ff <= wdat; // [R6]
    end
  end

  // Output data of the emulatable group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emul_out_ff <= RST_OUT_DATA;
    end else if (we_emul_out) begin
      emul_out_ff <= wdat; // [R6]
    end
  end

  // Pull-up enables of the bidirectional group; all pull-ups start off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_pu_ff <= RST_PULLUP; // [R10]
    end else if (we_bidir_pu) begin
      bidir_pu_ff <= wdat;
    end
  end

  // Pull-up enables of the input-only group.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_pu_ff <= RST_PULLUP; // [R10]
    end else if (we_input_pu) begin
      input_pu_ff <= wdat;
    end
  end

  // Pad controls follow the registers one cycle later. [R15]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_pad_ff <= '0;
    end else begin
      bidir_pad_ff <= nxt_bidir_pad;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_pad_ff <= '0;
    end else begin
      input_pad_ff <= nxt_input_pad;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_pad_ff <= '0;
    end else begin
      output_pad_ff <= nxt_output_pad;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emul_pad_ff <= '0;
    end else begin
      emul_pad_ff <= nxt_emul_pad;
    end
  end

  // Open-drain use: with output data zero, direction alone drives low or releases. [R14]
  assign bidir_pad      = bidir_pad_ff;
  assign input_pad      = input_pad_ff;
  assign output_pad     = output_pad_ff;
  assign emul_pad       = emul_pad_ff;
  assign bidir_alt_sel  = bidir_alt_ff;
  assign input_alt_sel  = input_alt_ff;
  assign output_alt_sel = output_alt_ff;
  assign hrdata         = hrdata_ff;
  assign hreadyout      = hreadyout_ff;
  assign hresp          = hresp_ff;

endmodule

// ### hdl/gpio_sync.sv
/*
  Two-stage synchroniser for one port group of pin inputs.
  Assumes the pins may change at any time relative to hclk.
*/
`timescale 1ns/100ps
module gpio_sync (
  // Clock and reset.
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Raw and synchronised levels.
  input  wire gpio_port_pkg::port_t  pin_raw,
  output      gpio_port_pkg::port_t  pin_sync
);
  import gpio_port_pkg::*;

  port_t meta_ff;
  port_t sync_ff;

  // Only the second stage reads the first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= RST_OUT_DATA;
      sync_ff <= RST_OUT_DATA;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;

endmodule

// ### pkg/gpio_port_pkg.sv
/*
  Package for the general-purpose port register set: register offsets, field widths, reset values,
  bus encodings and the packed structs that carry pin groups.
  Assumes a 32-bit AHB-Lite register bus with each register in one aligned word.
*/
package gpio_port_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 6;

  // Register byte offsets, one aligned word each.
  localparam logic [ADDR_W-1:0] OFS_BIDIR_ALT  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_INPUT_ALT  = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_ALT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_BIDIR_DIR  = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_EMUL_DIR   = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_BIDIR_OUT  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_OUT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_EMUL_OUT   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_BIDIR_IN   = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_INPUT_IN   = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_EMUL_IN    = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_BIDIR_PU   = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_INPUT_PU   = 6'h30;

  // Reset values; per-pin exceptions to the alternate and direction resets are applied through top-level parameters.
  localparam logic [PORT_W-1:0] RST_ALT      = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR      = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULLUP   = 8'h00;
  localparam logic [PORT_W-1:0] RST_OUT_DATA = 8'h00;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam int unsigned SYNC_STAGES  = 2;

  typedef logic [PORT_W-1:0] port_t;

  // Pad control for one group: output value, output enable, pull-up enable.
  typedef struct packed {
    port_t dout;
    port_t oe;
    port_t pu;
  } pad_ctrl_s;

  // Alternate module drive for one group.
  typedef struct packed {
    port_t dout;
    port_t oe;
  } alt_drive_s;

endpackage

// ### sim/gpio_pads_model.sv
/*
  Pad model for the bidirectional, input-only and emulatable pin groups.
  Assumes each pin outside the chip is held at the external level unless driven or pulled up.
*/
`timescale 1ns/100ps
module gpio_pads_model (
  // Pad controls from the register set.
  input  wire gpio_port_pkg::pad_ctrl_s bidir_pad,
  input  wire gpio_port_pkg::pad_ctrl_s input_pad,
  input  wire gpio_port_pkg::pad_ctrl_s emul_pad,
  // External levels.
  input  wire gpio_port_pkg::port_t     ext_b,
  input  wire gpio_port_pkg::port_t     ext_i,
  input  wire gpio_port_pkg::port_t     ext_e,
  // Resolved pin levels.
  output      gpio_port_pkg::port_t     pin_b,
  output      gpio_port_pkg::port_t     pin_i,
  output      gpio_port_pkg::port_t     pin_e
);
  import gpio_port_pkg::*;
  // A driven pad wins; an open pin with its pull-up on reads high.
  function automatic port_t lvl(input pad_ctrl_s p, input port_t e);
    return (p.oe & p.dout) | (~p.oe & (p.pu | e));
  endfunction
  assign pin_b = lvl(bidir_pad, ext_b);
  assign pin_i = lvl(input_pad, ext_i);
  assign pin_e = lvl(emul_pad, ext_e);
endmodule

// ### sim/gpio_port_regs_props.sv
/*
  Checker for the port register set, bound to its top module.
  Assumes one clock domain and the bus timing of the register set.
*/
`timescale 1ns/100ps
module gpio_port_regs_props (
  // Clock, reset and bus.
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  // Pins and alternate functions.
  input wire gpio_port_pkg::alt_drive_s output_alt_drv,
  input wire gpio_port_pkg::pad_ctrl_s  bidir_pad,
  input wire gpio_port_pkg::pad_ctrl_s  input_pad,
  input wire gpio_port_pkg::pad_ctrl_s  output_pad,
  input wire gpio_port_pkg::pad_ctrl_s  emul_pad,
  input wire gpio_port_pkg::port_t      output_alt_sel
);
  import gpio_port_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic  dp_ff;
  port_t cap_ff;
  wire   taken = hsel && hready && htrans[1];
  wire   alt_wr = taken && hwrite && haddr[5:0] == OFS_OUTPUT_ALT;
  // Keeps the last byte written to the output-group alternate select.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff  <= 1'b0;
      cap_ff <= '0;
    end else begin
      dp_ff  <= alt_wr;
      cap_ff <= dp_ff ? hwdata[7:0] : cap_ff;
    end
  end
  sequence alt_steady;
    ($stable(output_alt_sel) && $stable(output_alt_drv)) [*3];
  endsequence
  ready_const_a: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("error response seen");
  rdata_upper_a: assert property (taken && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  unmapped_read_a: assert property (taken && !hwrite && haddr[5:2] > 4'hC |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  input_undriven_a: assert property (input_pad.oe == 8'h00)
    else $error("input-only pin driven");
  emul_no_pullup_a: assert property (emul_pad.pu == 8'h00)
    else $error("pull-up on emulatable pin");
  pullup_tristate_a: assert property ((bidir_pad.pu & bidir_pad.oe) == 8'h00)
    else $error("pull-up on driven pin");
  out_alt_oe_a: assert property (alt_steady |-> output_pad.oe == (~output_alt_sel | output_alt_drv.oe))
    else $error("output group enable wrong");
  out_alt_data_a: assert property (alt_steady |-> ((output_pad.dout ^ output_alt_drv.dout) & output_alt_sel) == 0)
    else $error("alternate data not passed");
  alt_sel_write_a: assert property (dp_ff |-> ##[1:2] output_alt_sel == cap_ff)
    else $error("alternate select not updated");
endmodule

bind gpio_port_regs gpio_port_regs_props i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .output_alt_drv(output_alt_drv), .bidir_pad(bidir_pad), .input_pad(input_pad),
  .output_pad(output_pad), .emul_pad(emul_pad), .output_alt_sel(output_alt_sel)
);

// ### sim/tb_gpio_port_register_set.sv
/*
  Self-checking bench for the port register set with a pad model on the pin side.
  Assumes the one-cycle bus answer and registered pad outputs of the register set.
*/
`timescale 1ns/100ps
module tb_gpio_port_register_set;
  import gpio_port_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic        hreadyout;
  logic        hresp;
  alt_drive_s  bd = '0;
  alt_drive_s  od = '0;
  pad_ctrl_s   bp, ip, op, ep;
  port_t       bas, ias, oas, pb, pi, pe;
  port_t       eb = 8'h96;
  port_t       ei = 8'h69;
  port_t       ee = 8'hC3;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #4 hclk = ~hclk;

  gpio_port_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bidir_pin_in(pb), .input_pin_in(pi), .emul_pin_in(pe),
    .bidir_alt_drv(bd), .output_alt_drv(od), .bidir_pad(bp), .input_pad(ip), .output_pad(op),
    .emul_pad(ep), .bidir_alt_sel(bas), .input_alt_sel(ias), .output_alt_sel(oas));
  gpio_pads_model i_pads (.bidir_pad(bp), .input_pad(ip), .emul_pad(ep), .ext_b(eb), .ext_i(ei),
    .ext_e(ee), .pin_b(pb), .pin_i(pi), .pin_e(pe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    test_done();
  end

  initial begin
    do_reset();
    for (int i = 0; i < 13; i++) begin
      rdc(6'(4 * i), {24'h0, (i == 8) ? eb : (i == 9) ? ei : (i == 10) ? ee : 8'h00});
    end
    for (int i = 8; i < 16; i++) begin
      xfer(6'(4 * i), 1'b1, 32'hFFFF_FFFF);
      rdc(6'(4 * i), {24'h0, (i == 8) ? eb : (i == 9) ? ei : (i == 10) ? ee : (i > 12) ? 8'h00 : 8'hFF});
    end
    for (int i = 0; i < 13; i++) begin
      if (i < 8 || i > 10) begin
        xfer(6'(4 * i), 1'b1, {24'hFFFFFF, 8'(8'h5A ^ i)});
        rdc(6'(4 * i), {24'h0, 8'(8'h5A ^ i)});
      end
    end
    do_reset();
    xfer(OFS_OUTPUT_OUT, 1'b1, 32'h3C);
    repeat (2) @(posedge hclk);
    chk(op, {8'h3C, 8'hFF, 8'h00});
    od <= '{dout: 8'hAA, oe: 8'h05};
    xfer(OFS_OUTPUT_ALT, 1'b1, 32'h0F);
    repeat (2) @(posedge hclk);
    chk(oas, 8'h0F);
    chk(op, {8'h3A, 8'hF5, 8'h00});
    bd <= '{dout: 8'h00, oe: 8'h01};
    xfer(OFS_BIDIR_DIR, 1'b1, 32'hF0);
    xfer(OFS_BIDIR_OUT, 1'b1, 32'hA5);
    xfer(OFS_BIDIR_PU, 1'b1, 32'hFF);
    xfer(OFS_BIDIR_ALT, 1'b1, 32'h03);
    repeat (2) @(posedge hclk);
    chk(bp.oe, 8'hF1);
    chk(bp.pu, 8'h0E);
    chk(bp.dout & bp.oe, 8'hA0);
    chk(bas, 8'h03);
    repeat (2) @(posedge hclk);
    rdc(OFS_BIDIR_IN, 32'hAE);
    xfer(OFS_INPUT_ALT, 1'b1, 32'hF0);
    xfer(OFS_INPUT_PU, 1'b1, 32'h0F);
    repeat (2) @(posedge hclk);
    chk({ias, ip.oe, ip.pu}, 24'hF0000F);
    repeat (2) @(posedge hclk);
    rdc(OFS_INPUT_IN, 32'h6F);
    xfer(OFS_EMUL_OUT, 1'b1, 32'h00);
    xfer(OFS_EMUL_DIR, 1'b1, 32'h01);
    repeat (4) @(posedge hclk);
    rdc(OFS_EMUL_IN, 32'hC2);
    xfer(OFS_EMUL_DIR, 1'b1, 32'h00);
    ee <= 8'h3C;
    repeat (4) @(posedge hclk);
    rdc(OFS_EMUL_IN, 32'h3C);
    test_done();
  end
endmodule
